// *** logic/stm_defines.svh ***
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// Clock rate and documented times, each in its own unit.
`define STM_CLK_MHZ        100
`define STM_PULSE_MS       1
`define STM_DEACT_US       500
`define STM_ACT_US         5
`define STM_SIM_MS         100
`define STM_RESPONSE_US    3500
`define STM_DUTY_PCT       10

// Derived cycle counts.
`define STM_ACT_CYC        (`STM_ACT_US * `STM_CLK_MHZ)
`define STM_FALL_CYC       ((`STM_PULSE_MS * 1000 + `STM_DEACT_US) * `STM_CLK_MHZ)
`define STM_SIM_CYC        (`STM_SIM_MS * 1000 * `STM_CLK_MHZ)
`define STM_RESPONSE_CYC   (`STM_RESPONSE_US * `STM_CLK_MHZ)

// Register word indexes (byte address is four times the index).
`define STM_REG_CTRL       6'h00
`define STM_REG_STATUS     6'h01
`define STM_REG_FAULT_CLR  6'h02
`define STM_REG_IRQ_STAT   6'h03
`define STM_REG_IRQ_CLR    6'h04
`define STM_REG_IRQ_EN     6'h05

// Field layout.
`define STM_CTRL_REPORT_RST 2'h3
`define STM_AXIS_STRIDE    8
`define STM_ST_CHAN_A      0
`define STM_ST_CHAN_B      1
`define STM_ST_ACTIVE      2
`define STM_ST_WARN        3
`define STM_ST_FAULT       4
`define STM_ST_SIM         5
`define STM_ST_POWER       6
`define STM_IRQ_PER_AXIS   3
`define STM_IRQ_TRIG       0
`define STM_IRQ_FAULT      1
`define STM_IRQ_SIM        2
`define STM_IRQ_W          6
`define STM_CNT_W          24

`endif

// *** logic/stm_pkg.sv ***
`include "stm_defines.svh"

package stm_pkg;

  typedef logic [`STM_CNT_W-1:0] stm_cnt_type;

  typedef struct packed {
    logic        level;
    stm_cnt_type cnt;
  } stm_filt_state_type;

  typedef struct packed {
    logic [1:0]             a_sync1;
    logic [1:0]             a_sync2;
    logic [1:0]             b_sync1;
    logic [1:0]             b_sync2;
    logic [1:0]             en_sync1;
    logic [1:0]             en_sync2;
    logic [1:0]             report;
    logic [1:0]             active;
    logic [1:0]             warn;
    logic [1:0]             fault;
    logic [1:0]             sim;
    logic [1:0]             rearm;
    logic [1:0]             power;
    logic [1:0][`STM_CNT_W-1:0] sim_cnt;
    logic [`STM_IRQ_W-1:0]  irq_stat;
    logic [`STM_IRQ_W-1:0]  irq_en;
    logic                   ack;
    logic [31:0]            rdata;
  } stm_state_type;

endpackage

// *** logic/stm_chan_if.sv ***
`timescale 1ns/1ps

interface stm_chan_if;
  logic raw;
  logic level;
  modport user (output raw, input level);
  modport filt (input raw, output level);
endinterface

// *** logic/stm_chan_filter.sv ***
`timescale 1ns/1ps
`include "stm_defines.svh"

module stm_chan_filter #(
  parameter stm_pkg::stm_cnt_type RISE_CYC = `STM_CNT_W'(`STM_ACT_CYC),
  parameter stm_pkg::stm_cnt_type FALL_CYC = `STM_CNT_W'(`STM_FALL_CYC)
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  stm_chan_if.filt    ch
);

  stm_pkg::stm_filt_state_type q;
  stm_pkg::stm_filt_state_type d;
  stm_pkg::stm_cnt_type        limit;

  always_comb begin
    d     = q;
    limit = q.level ? FALL_CYC : RISE_CYC;
    if (ch.raw == q.level) begin
      d.cnt = '0;
    end else if (q.cnt + 1'b1 >= limit) begin
      // Low pulses shorter than the fall time never reach the output.
      d.level = ch.raw;  // A high is accepted after the short rise time.
      d.cnt   = '0;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ch.level = q.level;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  fall_after_full_a: assert property (
    $fell(q.level) |-> $past(q.cnt) == FALL_CYC - 1'b1 && !$past(ch.raw))
    else $error("channel dropped before the full low time");

  rise_after_delay_a: assert property (
    $rose(q.level) |-> $past(q.cnt) == RISE_CYC - 1'b1 && $past(ch.raw))
    else $error("channel rose without the activation delay");

endmodule

// *** logic/stm_monitor.sv ***
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "stm_defines.svh"

module stm_monitor #(
  parameter logic [`STM_CNT_W-1:0] FALL_CYC = `STM_CNT_W'(`STM_FALL_CYC),
  parameter logic [`STM_CNT_W-1:0] SIM_CYC  = `STM_CNT_W'(`STM_SIM_CYC)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        axis1_safety_channel_a_i,
  input  wire logic        axis1_safety_channel_b_i,
  input  wire logic        axis2_safety_channel_a_i,
  input  wire logic        axis2_safety_channel_b_i,
  input  wire logic [1:0]  axis_enable_i,
  output logic      [1:0]  power_enable_o,
  output logic      [1:0]  torque_off_warning_o,
  output logic      [1:0]  torque_off_fault_o,
  output logic      [1:0]  channel_simultaneity_fault_o,
  output logic             irq_o
);

  localparam logic [`STM_CNT_W-1:0] RISE_CYC = `STM_CNT_W'(`STM_ACT_CYC);

  stm_pkg::stm_state_type q;
  stm_pkg::stm_state_type d;

  stm_chan_if ch_a [2] ();
  stm_chan_if ch_b [2] ();

  logic [1:0]            fa;
  logic [1:0]            fb;
  logic [1:0]            both_hi;
  logic [1:0]            act_d;
  logic [1:0]            trig;
  logic [1:0]            clr;
  logic [`STM_IRQ_W-1:0] irq_set;
  logic                  req;
  logic                  wr;
  logic [5:0]            widx;
  logic [31:0]           status;

  assign ch_a[0].raw = q.a_sync2[0];
  assign ch_a[1].raw = q.a_sync2[1];
  assign ch_b[0].raw = q.b_sync2[0];
  assign ch_b[1].raw = q.b_sync2[1];
  assign fa          = {ch_a[1].level, ch_a[0].level};
  assign fb          = {ch_b[1].level, ch_b[0].level};

  for (genvar g = 0; g < 2; g++) begin : g_axis
    stm_chan_filter #(
      .RISE_CYC (RISE_CYC),
      .FALL_CYC (FALL_CYC)
    ) u_filt_a (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ch    (ch_a[g])
    );
    stm_chan_filter #(
      .RISE_CYC (RISE_CYC),
      .FALL_CYC (FALL_CYC)
    ) u_filt_b (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ch    (ch_b[g])
    );
  end

  assign req  = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr   = req && wb_we_i && wb_sel_i[0];
  assign widx = wb_adr_i[7:2];

  always_comb begin
    d          = q;
    d.a_sync1  = {axis2_safety_channel_a_i, axis1_safety_channel_a_i};
    d.b_sync1  = {axis2_safety_channel_b_i, axis1_safety_channel_b_i};
    d.en_sync1 = axis_enable_i;
    d.a_sync2  = q.a_sync1;
    d.b_sync2  = q.b_sync1;
    d.en_sync2 = q.en_sync1;
    clr        = '0;
    irq_set    = '0;
    status     = '0;

    if (wr && widx == `STM_REG_CTRL) begin
      d.report = wb_dat_i[1:0];
    end
    if (wr && widx == `STM_REG_FAULT_CLR) begin
      clr = wb_dat_i[1:0];
    end
    if (wr && widx == `STM_REG_IRQ_EN) begin
      d.irq_en = wb_dat_i[`STM_IRQ_W-1:0];
    end

    for (int i = 0; i < 2; i++) begin
      both_hi[i] = fa[i] && fb[i];

      // Disagreement time is counted and saturates once the fault is raised.
      if (fa[i] != fb[i]) begin
        if (q.sim_cnt[i] < SIM_CYC) begin
          d.sim_cnt[i] = q.sim_cnt[i] + 1'b1;
        end
      end else begin
        d.sim_cnt[i] = '0;
      end

      // Clear first, then set, so an event in the clearing cycle wins.
      if (clr[i]) begin
        d.fault[i] = 1'b0;
        d.sim[i]   = 1'b0;
      end
      if (fa[i] != fb[i] && q.sim_cnt[i] == SIM_CYC - 1'b1) begin
        d.sim[i] = 1'b1;
        irq_set[i*`STM_IRQ_PER_AXIS + `STM_IRQ_SIM] = 1'b1;
      end

      // A simultaneity fault or a low channel keeps the function active.
      act_d[i]    = !both_hi[i] || d.sim[i];
      trig[i]     = act_d[i] && !q.active[i];
      d.active[i] = act_d[i];

      if (trig[i] && q.report[i]) begin
        d.warn[i] = 1'b1;
        irq_set[i*`STM_IRQ_PER_AXIS + `STM_IRQ_TRIG] = 1'b1;
        if (q.en_sync2[i]) begin
          d.fault[i] = 1'b1;
          d.rearm[i] = 1'b1;
          irq_set[i*`STM_IRQ_PER_AXIS + `STM_IRQ_FAULT] = 1'b1;
        end
      end else if (!act_d[i]) begin
        d.warn[i] = 1'b0;
      end

      // Restart waits for the enable to be seen low once after the trigger.
      if (!q.en_sync2[i] && !(trig[i] && q.report[i])) begin
        d.rearm[i] = 1'b0;
      end

      // Power only with both channels, the enable, and no fault pending.
      d.power[i] = both_hi[i] && q.en_sync2[i] && !act_d[i] && !q.fault[i]
                   && !q.sim[i] && !q.rearm[i];

      status[i*`STM_AXIS_STRIDE + `STM_ST_CHAN_A] = fa[i];
      status[i*`STM_AXIS_STRIDE + `STM_ST_CHAN_B] = fb[i];
      status[i*`STM_AXIS_STRIDE + `STM_ST_ACTIVE] = q.active[i];
      status[i*`STM_AXIS_STRIDE + `STM_ST_WARN]   = q.warn[i];
      status[i*`STM_AXIS_STRIDE + `STM_ST_FAULT]  = q.fault[i];
      status[i*`STM_AXIS_STRIDE + `STM_ST_SIM]    = q.sim[i];
      status[i*`STM_AXIS_STRIDE + `STM_ST_POWER]  = q.power[i];
    end

    if (wr && widx == `STM_REG_IRQ_CLR) begin
      d.irq_stat = q.irq_stat & ~wb_dat_i[`STM_IRQ_W-1:0];
    end
    d.irq_stat = d.irq_stat | irq_set;

    d.ack   = req;
    d.rdata = '0;
    if (req && !wb_we_i) begin
      unique case (widx)
        `STM_REG_CTRL:     d.rdata = {30'h0000_0000, q.report};
        `STM_REG_STATUS:   d.rdata = status;
        `STM_REG_IRQ_STAT: d.rdata = {26'h000_0000, q.irq_stat};
        `STM_REG_IRQ_EN:   d.rdata = {26'h000_0000, q.irq_en};
        default:           d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.report <= `STM_CTRL_REPORT_RST;
      q.active <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o                     = q.ack;
  assign wb_dat_o                     = q.rdata;
  assign power_enable_o               = q.power;
  assign torque_off_warning_o         = q.warn;
  assign torque_off_fault_o           = q.fault;
  assign channel_simultaneity_fault_o = q.sim;
  assign irq_o                        = |(q.irq_stat & q.irq_en);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  power_cut_a: assert property (
    !(fa[0] && fb[0]) |=> !q.power[0])
    else $error("axis 1 power not cut after channel low");

  power_off_active_a: assert property (
    q.active[1] |-> !q.power[1])
    else $error("axis 2 powered while torque off active");

  torque_gate_a: assert property (
    q.power[0] |-> $past(fa[0] && fb[0] && q.en_sync2[0]))
    else $error("axis 1 powered without both channels and enable");

  sim_timing_a: assert property (
    $rose(q.sim[0]) |-> $past(q.sim_cnt[0]) == SIM_CYC - 1'b1 && !q.power[0])
    else $error("simultaneity fault at wrong time");

  report_gate_a: assert property (
    $rose(q.warn[0]) || $rose(q.fault[0]) |-> $past(q.report[0]))
    else $error("message raised with reporting off");

  report_reset_a: assert property (
    $past(rst_i) |-> q.report == `STM_CTRL_REPORT_RST)
    else $error("report enable not one after reset");

  chan_status_a: assert property (
    wb_ack_o && $past(!wb_we_i && widx == `STM_REG_STATUS)
      |-> wb_dat_o[`STM_ST_CHAN_A] == $past(fa[0]) && wb_dat_o[`STM_ST_CHAN_B] == $past(fb[0]))
    else $error("channel status read wrong");

  active_status_a: assert property (
    q.active[0] == $past(!(fa[0] && fb[0]) || d.sim[0]))
    else $error("active status mismatch");

  fault_hold_a: assert property (
    q.fault[1] && !clr[1] |=> q.fault[1] && !q.power[1])
    else $error("torque fault dropped without clear");

endmodule

// *** tb/stm_ctrl_model.sv ***
`timescale 1ns/1ps

// Safety controller: one output per channel; a test pulse pulls a channel low.
module stm_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] hold_i,
  input  wire logic [3:0] pulse_i,
  output logic      [3:0] chan_o
);
  always_ff @(posedge clk_i) begin
    chan_o <= hold_i & ~pulse_i;
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps

module tb;
  localparam int FALL = 20;
  localparam int SIM  = 200;
  localparam int RESP = FALL + 6;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic [3:0]  hold  = 4'h0;
  logic [3:0]  pulse = 4'h0;
  logic [3:0]  chan;
  logic [1:0]  en    = 2'h0;
  logic [1:0]  pw;
  logic [1:0]  warn;
  logic [1:0]  flt;
  logic [1:0]  sim;
  int          n_errors = 0;
  int          checks_done = 0;
  int          k;
  int          t;

  always #5 clk_i = ~clk_i;

  stm_ctrl_model model (.clk_i(clk_i), .hold_i(hold), .pulse_i(pulse), .chan_o(chan));

  stm_monitor #(.FALL_CYC(24'h14), .SIM_CYC(24'hc8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .axis1_safety_channel_a_i(chan[0]), .axis1_safety_channel_b_i(chan[1]),
    .axis2_safety_channel_a_i(chan[2]), .axis2_safety_channel_b_i(chan[3]),
    .axis_enable_i(en), .power_enable_o(pw), .torque_off_warning_o(warn),
    .torque_off_fault_o(flt), .channel_simultaneity_fault_o(sim), .irq_o(irq));

  function automatic logic [7:0] stat(input logic [1:0] ch, input logic a, w, f, s, p);
    return {1'b0, p, s, f, w, a, ch};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    chk("bus ack", 1, n < 20);
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wpow(input int i, input logic v, input int lim);
    t = 0;
    while (pw[i] !== v && t < lim) begin
      @(posedge clk_i);
      t++;
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    summarize();
  end

  initial begin
    void'($urandom(22905));
    tick(5);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 8'h00, 0);
    chk("ctrl reset", 32'h3, rd);
    bus(1, 8'hfc, $urandom);
    bus(0, 8'hfc, 0);
    chk("unmapped", 0, rd);
    bus(1, 8'h14, 32'h3f);
    hold <= 4'hf;
    en <= 2'b11;
    wpow(0, 1, 700);
    chk("activation", 1, t >= 498 && t <= 515);
    bus(0, 8'h04, 0);
    chk("status run", {16'h0, {2{stat(2'b11, 0, 0, 0, 0, 1)}}}, rd);
    for (k = 0; k < 6; k++) begin
      t = 1 + $urandom % (FALL - 2);
      pulse <= 4'h1 << ($urandom % 4);
      tick(t);
      pulse <= 4'h0;
      tick(10 * t);
      chk("pulse", 8'hc0, {pw, warn, flt, sim});
    end
    en <= 2'b01;
    tick(8);
    chk("enable low", 4'b0100, {pw, warn});
    en <= 2'b11;
    wpow(1, 1, 10);
    chk("enable back", 1, t < 10);
    hold <= 4'hc;
    wpow(0, 0, RESP + 5);
    chk("response", 1, t >= FALL && t <= RESP);
    tick(2);
    chk("trigger", 5'b10101, {irq, warn, flt});
    bus(0, 8'h04, 0);
    chk("status trig", stat(2'b00, 1, 1, 1, 0, 0), rd[7:0]);
    bus(0, 8'h0c, 0);
    chk("irq stat", 32'h3, rd);
    bus(1, 8'h14, 0);
    chk("irq mask", 0, irq);
    bus(1, 8'h14, 32'h3f);
    bus(1, 8'h10, 32'h3);
    chk("irq clr", 0, irq);
    hold <= 4'hf;
    tick(600);
    chk("fault holds", 2'b00, {pw[0], warn[0]});
    bus(1, 8'h08, 32'h1);
    tick(5);
    chk("need disable", 0, pw[0]);
    en <= 2'b10;
    tick(5);
    en <= 2'b11;
    wpow(0, 1, 10);
    chk("restart", 1, t < 10);
    bus(1, 8'h00, 32'h1);
    hold <= 4'h3;
    wpow(1, 0, RESP + 5);
    tick(3);
    chk("silent", 2'b00, {warn[1], flt[1]});
    bus(0, 8'h0c, 0);
    chk("silent irq", 0, rd);
    hold <= 4'hf;
    wpow(1, 1, 600);
    chk("silent back", 1, t < 600);
    hold <= 4'hb;
    t = 0;
    while (sim[1] !== 1'b1 && t < 400) begin
      @(posedge clk_i);
      t++;
    end
    chk("sim time", 1, t >= SIM && t <= SIM + FALL + 10);
    bus(0, 8'h0c, 0);
    chk("sim irq", 32'h20, rd);
    hold <= 4'hf;
    tick(600);
    chk("sim holds", 0, pw[1]);
    bus(1, 8'h08, 32'h2);
    wpow(1, 1, 20);
    chk("sim clear", 1, t < 20);
    summarize();
  end
endmodule
